// ==== frame_replay_scheduler_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module frame_replay_scheduler_tb;
	logic MCLK = '0, RESET = '1, IS_LIN = '0, FILTER_CLEAR = '0, FILTER_WR = '0, IN_VALID = '0;
	logic stall = '1, IN_READY, TX_VALID, TX_READY;
	logic [1:0] TIMING_MODE = '0;
	logic [3:0] FILTER_COUNT;
	logic [31:0] FILTER_ID = '0, n_got;
	frs_pkg::frs_frame_t IN_FRAME = '0;
	frs_pkg::frs_tx_t TX_FRAME, got;
	int num_errors = 0, n_compared = 0, i, w;
	// 25 MHz
	always #20 MCLK = ~MCLK;
	frs_frame_replay_scheduler dut (.MCLK(MCLK), .RESET(RESET), .TIMING_MODE(TIMING_MODE),
		.IS_LIN(IS_LIN), .FILTER_CLEAR(FILTER_CLEAR), .FILTER_WR(FILTER_WR), .FILTER_ID(FILTER_ID),
		.IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_FRAME(IN_FRAME), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .TX_FRAME(TX_FRAME), .FILTER_COUNT(FILTER_COUNT));
	frs_bus_model bus (.clk(MCLK), .rst(RESET), .tx_valid(TX_VALID), .tx_frame(TX_FRAME),
		.stall(stall), .tx_ready(TX_READY), .n_got(n_got), .got(got));
	task chk(string n, logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task conclude;
		$display("errors %0d of %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// List write: c empties it, else appends
	task fl(logic c, logic [31:0] id, logic [3:0] ec);
		@(posedge MCLK);
		FILTER_CLEAR <= c;
		FILTER_WR <= !c;
		FILTER_ID <= id;
		@(posedge MCLK);
		FILTER_CLEAR <= '0;
		FILTER_WR <= '0;
		@(negedge MCLK);
		chk("count", FILTER_COUNT, ec);
	endtask
	// One frame; hi below 0 means it must stay off the bus
	task xf(logic [1:0] k, logic [31:0] id, st, logic rsp, int lo, hi);
		logic [31:0] n0;
		@(posedge MCLK);
		IN_FRAME <= '{k, id, st, {st, id}, 4'h8};
		IN_VALID <= '1;
		i = 0;
		do @(negedge MCLK); while (IN_READY !== 1'b1 && ++i < 400);
		@(posedge MCLK);
		IN_VALID <= '0;
		n0 = n_got;
		w = 0;
		do @(negedge MCLK); while (n_got === n0 && ++w < (hi < 0 ? 40 : 300));
		if (hi < 0) chk("dropped", n_got, n0);
		else begin
			chk("id", got.id, id);
			chk("rsp", got.response, rsp);
			chk("data", got.payload[31:0], id);
			chk("len", got.len, 32'h8);
			chk("gap", w >= lo && w <= hi, 1);
		end
		if (i == 400 || w == 300) begin
			num_errors++;
			conclude;
		end
	endtask
	// Filtering, CAN then LIN, list untouched in immediate
	task s_filt;
		fl('0, 32'h123, 4'h1);
		fl('0, 32'h2000_0456, 4'h2);
		xf(2'h0, 32'h123, '0, 1, 0, 6);
		@(posedge MCLK);
		stall <= '0;
		TIMING_MODE <= 2'h1;
		xf(2'h0, 32'h123, '0, 0, 0, -1);
		xf(2'h0, 32'h124, '0, 1, 0, 3);
		@(posedge MCLK);
		TIMING_MODE <= 2'h2;
		xf(2'h0, 32'h123, '0, 1, 0, 3);
		xf(2'h0, 32'h2000_0123, '0, 0, 0, -1);
		xf(2'h0, 32'h2000_0456, '0, 1, 0, 3);
		fl('1, '0, 4'h0);
		fl('0, 32'h23, 4'h1);
		@(posedge MCLK);
		IS_LIN <= '1;
		xf(2'h0, 32'h23, '0, 1, 0, 3);
		xf(2'h0, 32'h24, '0, 0, 0, 3);
		fl('1, '0, 4'h0);
		@(posedge MCLK);
		IS_LIN <= '0;
		TIMING_MODE <= 2'h1;
		xf(2'h0, 32'h24, '0, 1, 0, 3);
	endtask
	// Full list: ninth write ignored, eighth entry still filters
	task s_full;
		for (int k = 0; k < 9; k++) begin
			fl('0, 32'h100 + k, (k < 8) ? 4'(k + 1) : 4'h8);
		end
		xf(2'h0, 32'h107, '0, 0, 0, -1);
		xf(2'h0, 32'h108, '0, 1, 0, 3);
		fl('1, '0, 4'h0);
	endtask
	// Replay timing, stamps in clock ticks
	task s_time;
		xf(2'h1, '0, '0, 0, 0, -1);
		xf(2'h0, 32'h10, 32'h3E8, 1, 0, 3);
		xf(2'h0, 32'h10, 32'h3FC, 1, 15, 22);
		xf(2'h0, 32'h10, 32'h3F2, 1, 0, 3);
		xf(2'h0, 32'h10, 32'h410, 1, 8, 20);
		xf(2'h0, 32'h10, 32'h384, 1, 0, 3);
		xf(2'h0, 32'h10, 32'h3A2, 1, 25, 32);
		xf(2'h2, '0, 32'h1770, 0, 0, -1);
		xf(2'h0, 32'h10, 32'h17D4, 1, 40, 70);
	endtask
	initial begin
		repeat (16) @(posedge MCLK);
		RESET <= '0;
		s_filt;
		s_full;
		s_time;
		conclude;
	end
endmodule // frame_replay_scheduler_tb
`default_nettype wire

// ==== frs_bus_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module frs_bus_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_valid,
	input wire frs_pkg::frs_tx_t tx_frame,
	input wire logic stall,
	output logic tx_ready,
	output logic [31:0] n_got,
	output frs_pkg::frs_tx_t got
);
	logic [1:0] wait_q;
	// Slow engine holds each frame three cycles
	assign tx_ready = !stall || wait_q == 2'h3;
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_q <= '0;
			n_got <= '0;
		end else begin
			wait_q <= tx_valid && !tx_ready ? wait_q + 2'h1 : '0;
			if (tx_valid && tx_ready) begin
				n_got <= n_got + 32'h1;
				got <= tx_frame;
			end
		end
	end
endmodule // frs_bus_model
`default_nettype wire

// ==== frs_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module frs_checker (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic IN_VALID,
	input wire logic IN_READY,
	input wire frs_pkg::frs_frame_t IN_FRAME,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire frs_pkg::frs_tx_t TX_FRAME,
	input wire logic FILTER_CLEAR,
	input wire logic [3:0] FILTER_COUNT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	wire tk = IN_VALID && IN_READY;
	sequence s_pass; !IN_READY ##1 IN_READY; endsequence
	// Handshake, one frame in flight
	property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_FRAME); endproperty
	a_hold: assert property (p_hold) else $error("tx moved");
	property p_next; TX_VALID && TX_READY |=> !TX_VALID && IN_READY; endproperty
	a_next: assert property (p_next) else $error("stuck");
	property p_one; TX_VALID |-> !IN_READY; endproperty
	a_one: assert property (p_one) else $error("overlap");
	// A non-trigger frame leaves IDLE once taken
	property p_take; tk && IN_FRAME.kind != 2'h2 |=> !IN_READY; endproperty
	a_take: assert property (p_take) else $error("no take");
	property p_idle; IN_READY && !IN_VALID |=> IN_READY && !TX_VALID; endproperty
	a_idle: assert property (p_idle) else $error("idle tx");
	property p_fclr; FILTER_CLEAR |=> FILTER_COUNT == 4'h0; endproperty
	a_fclr: assert property (p_fclr) else $error("list not cleared");
	// Delay and trigger frames stay off the bus
	property p_trig; tk && IN_FRAME.kind == 2'h2 |=> !TX_VALID ##1 IN_READY; endproperty
	a_trig: assert property (p_trig) else $error("trigger");
	property p_dly; tk && IN_FRAME.kind == 2'h1 && IN_FRAME.stamp == '0 |=> s_pass; endproperty
	a_dly: assert property (p_dly) else $error("delay 0");
	property p_dtx; tk && IN_FRAME.kind == 2'h1 |=> !TX_VALID [*2]; endproperty
	a_dtx: assert property (p_dtx) else $error("delay sent");
endmodule // frs_checker
bind frs_frame_replay_scheduler frs_checker u_chk (.MCLK(MCLK), .RESET(RESET),
	.IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_FRAME(IN_FRAME), .TX_VALID(TX_VALID),
	.TX_READY(TX_READY), .TX_FRAME(TX_FRAME), .FILTER_CLEAR(FILTER_CLEAR),
	.FILTER_COUNT(FILTER_COUNT));
`default_nettype wire

// ==== frs_defines.svh ====
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH

// Transmit timing mode codes
`define FRS_MODE_IMMEDIATE 2'h0
`define FRS_MODE_EXCLUSIVE 2'h1
`define FRS_MODE_INCLUSIVE 2'h2

// Filter entry layout
`define FRS_EXT_BIT 29
`define FRS_STD_ID_MASK 32'h0000_07FF
`define FRS_EXT_ID_MASK 32'h1FFF_FFFF
`define FRS_LIN_ID_MASK 32'h0000_003F

// Filter list size and widths
`define FRS_FILTER_DEPTH 8
`define FRS_FILTER_IDX_W 3
`define FRS_TIME_W 32

// Frame types
`define FRS_TYPE_DATA 2'h0
`define FRS_TYPE_DELAY 2'h1
`define FRS_TYPE_TRIGGER 2'h2

`endif

// ==== frs_frame_replay_scheduler.sv ====
// What this block does
// - Timing mode: 0 immediate, 1 exclusive replay, 2 inclusive replay.
// - Immediate mode sends queued frames in order without waiting.
// - Exclusive replay suppresses frames matching a filter entry.
// - Inclusive replay sends only frames matching a filter entry.
// - On LIN the header always goes; filtering decides only the response.
// - Exclusive replay with empty filter list replays every frame.
// - CAN entry bit 29 set means extended identifier, clear standard.
// - Standard compares bits 0 to 10; extended compares bits 0 to 28.
// - LIN entry is an unprotected identifier 0 to 63.
// - First replayed frame sets start time, sends at once; later frames at delta.
// - Stamp at or before start time: send now, adopt as new start.
// - Stamp before previous but after start: send now, keep start.
// - Delay frame waits its duration, possibly 0, then next is first frame.
// - Start trigger frame becomes new first frame, its time is start time.
`timescale 1ns/100ps
`default_nettype none
`include "frs_defines.svh"

module frs_frame_replay_scheduler (
	// Clock and synchronous reset
	input wire logic MCLK,
	input wire logic RESET,

	// Mode and interface select, same clock domain
	input wire logic [1:0] TIMING_MODE,
	input wire logic IS_LIN,

	// Filter list load port
	input wire logic FILTER_CLEAR,
	input wire logic FILTER_WR,
	input wire logic [31:0] FILTER_ID,

	// Frame queue side
	input wire logic IN_VALID,
	output logic IN_READY,
	input wire frs_pkg::frs_frame_t IN_FRAME,

	// Bus engine side
	output logic TX_VALID,
	input wire logic TX_READY,
	output frs_pkg::frs_tx_t TX_FRAME,

	// Entry count for software
	output logic [3:0] FILTER_COUNT
);

	frs_pkg::frs_regs_t r_q;
	frs_pkg::frs_regs_t r_d;
	logic hit;
	logic send_resp;
	logic [31:0] elapsed;

	// Normalise a filter entry or frame id to its comparable form
	// Keys keep the format flag, so a standard and an extended id
	// with equal low bits never match each other
	// Only the low six bits count on LIN; upper bits are ignored
	function automatic logic [31:0] frs_key(input logic [31:0] v, input logic lin);
		logic [31:0] k;
		k = 32'h0000_0000;
		if (lin) begin
			k = v & `FRS_LIN_ID_MASK;
		end else if (v[`FRS_EXT_BIT]) begin
			k = (v & `FRS_EXT_ID_MASK) | (32'h0000_0001 << `FRS_EXT_BIT);
		end else begin
			k = v & `FRS_STD_ID_MASK;
		end
		return k;
	endfunction

	// Filter lookup over all stored entries
	// All eight entries compared in parallel; the list is small,
	// so the comparator tree stays shallow
	always_comb begin
		hit = 1'b0;
		for (int i = 0; i < `FRS_FILTER_DEPTH; i++) begin
			if ((i < int'(r_q.filter_count)) &&
				(frs_key(r_q.filter[i], IS_LIN) == frs_key(IN_FRAME.id, IS_LIN))) begin
				hit = 1'b1;
			end
		end
	end

	// Response decision per mode
	// Mode 3 is undefined; it gets replay timing like modes 1 and 2
	// with every response sent
	always_comb begin
		send_resp = 1'b1;
		if (TIMING_MODE == `FRS_MODE_EXCLUSIVE) begin
			// drop listed, empty list never hits
			send_resp = !hit;
		end else if (TIMING_MODE == `FRS_MODE_INCLUSIVE) begin
			send_resp = hit;
		end
	end

	// Unsigned difference survives a timebase rollover,
	// as long as no single wait exceeds the counter range
	assign elapsed = r_q.timebase - r_q.start_tick;

	// Next-state logic for the whole scheduler
	// One process builds the whole next state and IN_READY; TX_VALID,
	// TX_FRAME and FILTER_COUNT are assigned after the register
	always_comb begin
		r_d = r_q;
		IN_READY = 1'b0;
		// free-running timebase
		// One tick is one MCLK period
		r_d.timebase = r_q.timebase + 32'h0000_0001;
		// Filter list writes; full list ignores further writes
		// Clear wins over a write in the same cycle
		// A full list drops writes silently; software must clear first
		if (FILTER_CLEAR) begin
			r_d.filter_count = 4'h0;
		end else if (FILTER_WR && (r_q.filter_count < 4'(`FRS_FILTER_DEPTH))) begin
			r_d.filter[r_q.filter_count[`FRS_FILTER_IDX_W-1:0]] = FILTER_ID;
			r_d.filter_count = r_q.filter_count + 4'h1;
		end
		case (r_q.state)
			frs_pkg::FRS_IDLE: begin
				// Only IDLE accepts, so one frame is in flight at a time
				IN_READY = 1'b1;
				if (IN_VALID) begin
					// Latch now; the bus side only sees registered data
					r_d.tx.id = IN_FRAME.id;
					r_d.tx.payload = IN_FRAME.payload;
					r_d.tx.len = IN_FRAME.len;
					r_d.tx.response = send_resp;
					r_d.delta = 32'h0000_0000;
					// Delay and trigger frames never reach the bus engine
					if (IN_FRAME.kind == `FRS_TYPE_DELAY) begin
						r_d.delay_left = IN_FRAME.stamp;
						r_d.have_start = 1'b0;
						r_d.state = frs_pkg::FRS_DELAY;
					end else if (IN_FRAME.kind == `FRS_TYPE_TRIGGER) begin
						r_d.have_start = 1'b1;
						r_d.start_stamp = IN_FRAME.stamp;
						r_d.start_tick = r_q.timebase;
						r_d.prev_stamp = IN_FRAME.stamp;
						// Stays in IDLE: no bus traffic to make
					end else if (TIMING_MODE == `FRS_MODE_IMMEDIATE) begin
						r_d.state = frs_pkg::FRS_SEND;
					end else if (!r_q.have_start || (IN_FRAME.stamp <= r_q.start_stamp)) begin
						r_d.have_start = 1'b1;
						r_d.start_stamp = IN_FRAME.stamp;
						r_d.start_tick = r_q.timebase;
						r_d.prev_stamp = IN_FRAME.stamp;
						r_d.state = frs_pkg::FRS_SEND;
					end else if (IN_FRAME.stamp < r_q.prev_stamp) begin
						// keep start, send now
						// Later frames keep the original spacing
						r_d.prev_stamp = IN_FRAME.stamp;
						r_d.state = frs_pkg::FRS_SEND;
					end else begin
						// schedule at delta
						// Measured from the start frame, not the previous one
						r_d.delta = IN_FRAME.stamp - r_q.start_stamp;
						r_d.prev_stamp = IN_FRAME.stamp;
						r_d.state = frs_pkg::FRS_WAIT;
					end
				end
			end
			frs_pkg::FRS_WAIT: begin
				// release on delta
				// Stamps behind the start are caught in IDLE, so no negative delta
				// Greater-or-equal so a late check still releases the frame
				if (elapsed >= r_q.delta) begin
					r_d.state = frs_pkg::FRS_SEND;
				end
			end
			frs_pkg::FRS_SEND: begin
				// CAN frame with no response is dropped whole
				// LIN keeps its slot, so the header goes even without response
				if (!IS_LIN && !r_q.tx.response) begin
					r_d.state = frs_pkg::FRS_IDLE;
				end else if (TX_READY) begin
					r_d.state = frs_pkg::FRS_IDLE;
				end
			end
			frs_pkg::FRS_DELAY: begin
				// zero delay ends at once
				// Duration in timebase ticks; N takes N+1 cycles
				if (r_q.delay_left == 32'h0000_0000) begin
					r_d.state = frs_pkg::FRS_IDLE;
				end else begin
					r_d.delay_left = r_q.delay_left - 32'h0000_0001;
				end
			end
			default: begin
				// Unused encoding recovers to IDLE
				r_d.state = frs_pkg::FRS_IDLE;
			end
		endcase
	end

	// State register with synchronous reset
	// Reset clears list, start time and timebase together
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	// Header always offered on LIN; response flag carries the filter result
	// Handshake combinational from state; data straight from flip-flops
	assign TX_VALID = (r_q.state == frs_pkg::FRS_SEND) && (IS_LIN || r_q.tx.response);
	assign TX_FRAME = r_q.tx;
	assign FILTER_COUNT = r_q.filter_count;

endmodule // frs_frame_replay_scheduler

`default_nettype wire

// ==== frs_pkg.sv ====
package frs_pkg;

	typedef enum logic [1:0] {
		FRS_IDLE,
		FRS_WAIT,
		FRS_SEND,
		FRS_DELAY
	} frs_state_t;

	// Queued frame as seen by the scheduler
	typedef struct packed {
		logic [1:0] kind;
		logic [31:0] id;
		logic [31:0] stamp;
		logic [63:0] payload;
		logic [3:0] len;
	} frs_frame_t;

	// Frame presented to the bus engine
	typedef struct packed {
		logic [31:0] id;
		logic [63:0] payload;
		logic [3:0] len;
		logic response;
	} frs_tx_t;

	typedef struct packed {
		frs_state_t state;
		logic [31:0] timebase;
		logic have_start;
		logic [31:0] start_stamp;
		logic [31:0] start_tick;
		logic [31:0] prev_stamp;
		logic [31:0] delta;
		logic [31:0] delay_left;
		frs_tx_t tx;
		logic [7:0] [31:0] filter;
		logic [3:0] filter_count;
	} frs_regs_t;

endpackage
